// >>> design/lcam_top.sv
// Legacy compatibility address map: data-space decode and feature trim.
// Assumes the fuse pin is static after reset and APB on the same pclk.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module lcam_top
  import lcam_pkg::*;
#(
  parameter logic [5:0] BAUD_HIGH_CH0_IO = 6'h20,
  parameter logic [5:0] BAUD_HIGH_CH1_IO = 6'h3c
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic legacy_compat_fuse,
  input wire lcam_cpu_req_s cpu_req,
  output lcam_map_sel_s map_sel,
  output logic map_valid,
  output logic mode_ready,
  output lcam_feat_s feat
);

  // Fuse synchroniser and lock
  logic fuse_s1_reg;
  logic fuse_s2_reg;
  logic fuse_s3_reg;
  // Mode is captured once per reset
  lcam_mode_e mode_reg;
  lcam_mode_e mode_next;
  logic [2:0] settle_reg;
  logic [2:0] settle_next;
  logic legacy_reg;
  logic legacy_next;
  logic fuse_agree;

  // Pin counts once stages two and three agree
  assign fuse_agree = (fuse_s2_reg == fuse_s3_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_s1_reg <= 1'b0;
      fuse_s2_reg <= 1'b0;
      fuse_s3_reg <= 1'b0;
    end else begin
      fuse_s1_reg <= legacy_compat_fuse;
      fuse_s2_reg <= fuse_s1_reg;
      fuse_s3_reg <= fuse_s2_reg;
    end
  end

  always_comb begin
    mode_next = mode_reg;
    settle_next = settle_reg;
    legacy_next = legacy_reg;
    case (mode_reg)
      LCAM_SETTLE: begin
        // Let the synchroniser fill before trusting it
        settle_next = settle_reg + 3'h1;
        if (settle_reg == FUSE_SETTLE_CYCLES) begin
          mode_next = LCAM_CAPTURE;
        end
      end
      LCAM_CAPTURE: begin
        // A pin still moving keeps the machine here
        if (fuse_agree) begin
          legacy_next = fuse_s3_reg;
          mode_next = LCAM_LOCKED;
        end
      end
      LCAM_LOCKED: begin
        // Only presetn leaves this state
        mode_next = LCAM_LOCKED;
      end
      default: begin
        mode_next = LCAM_SETTLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= LCAM_SETTLE;
      settle_reg <= 3'h0;
      legacy_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      settle_reg <= settle_next;
      legacy_reg <= legacy_next;
    end
  end

  wire locked = (mode_reg == LCAM_LOCKED);

  // Inclusive address window test
  function automatic logic in_span(
    input logic [15:0] x,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    return (x >= lo) && (x <= hi);
  endfunction

  // Address decode
  wire [15:0] a = cpu_req.addr;
  wire data_acc = cpu_req.valid && !cpu_req.is_io;
  // Short I/O reaches only the 64 legacy locations
  wire short_acc = cpu_req.valid && cpu_req.is_io && (a < 16'(IO_ENTRIES));
  wire in_regfile = data_acc && (a <= REGFILE_END);
  wire in_io_data = data_acc && in_span(a, IO_BASE, IO_END);
  wire in_ext = data_acc && in_span(a, EXT_BASE, EXT_END);
  wire ext_live = in_ext && !legacy_reg;
  // Legacy mode folds the extended window back into RAM
  wire [15:0] ram_base = legacy_reg ? RAM_BASE_LEGACY : RAM_BASE_NATIVE;
  wire in_ram = data_acc && (a >= ram_base);
  wire [15:0] io_off = a - IO_BASE;
  // Short I/O number n and data address n+0x20 reach the same register
  wire [5:0] io_idx = short_acc ? a[5:0] : io_off[5:0];
  wire io_any = short_acc || in_io_data;
  wire [15:0] ext_off = a - EXT_BASE;
  wire [15:0] ram_off = a - ram_base;

  lcam_map_sel_s sel_next;
  always_comb begin
    sel_next = '0;
    sel_next.regfile_hit = in_regfile;
    sel_next.io_hit = io_any;
    sel_next.ext_hit = ext_live;
    sel_next.ram_hit = in_ram;
    sel_next.we = cpu_req.we;
    sel_next.io_index = io_any ? io_idx : 6'h00;
    sel_next.ext_index = ext_live ? ext_off[7:0] : 8'h00;
    sel_next.ram_offset = in_ram ? ram_off : 16'h0000;
    // Fixed locations regardless of mode
    sel_next.baud_high_ch0 = io_any && (io_idx == BAUD_HIGH_CH0_IO);
    sel_next.baud_high_ch1 = io_any && (io_idx == BAUD_HIGH_CH1_IO);
  end

  // Software feature gates
  logic [1:0] ctrl_reg;
  logic ext_seen_reg;
  logic io_seen_reg;
  lcam_feat_s feat_next;
  // Gates stay low until lock, in either mode
  always_comb begin
    feat_next.ext_vectors_en = locked && !legacy_reg;
    feat_next.wdt_timed_seq_en = locked && !legacy_reg;
    feat_next.rx_double_buf_en = locked && !legacy_reg;
    feat_next.pcint_en = locked && !legacy_reg && ctrl_reg[CTRL_PCINT_BIT];
    feat_next.second_wide_timer_en = locked && !legacy_reg
                                     && ctrl_reg[CTRL_TIMER2_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_sel <= '0;
      map_valid <= 1'b0;
      mode_ready <= 1'b0;
      feat <= '0;
    end else begin
      // Nothing decodes until the mode is locked
      map_sel <= locked ? sel_next : '0;
      map_valid <= locked && cpu_req.valid;
      mode_ready <= locked;
      feat <= feat_next;
    end
  end

  // APB slave: one wait state, then pready
  wire apb_acc = psel && penable;
  wire apb_done = apb_acc && pready;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_stat = (paddr == OFS_STATUS);
  wire [31:0] stat_word = {28'h0000000, io_seen_reg, ext_seen_reg, locked, legacy_reg};
  wire [31:0] ctrl_word = {30'h0, ctrl_reg};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0);
  // Unmapped offsets and STATUS writes answer with pslverr
  wire bad_addr = !(hit_ctrl || hit_stat) || (pwrite && hit_stat);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      ext_seen_reg <= 1'b0;
      io_seen_reg <= 1'b0;
    end else begin
      // pready skips the first access cycle: one wait state
      pready <= apb_acc && !pready;
      prdata <= (apb_acc && !pready && !pwrite) ? rd_word : 32'h00000000;
      pslverr <= apb_acc && !pready && bad_addr;
      if (apb_done && pwrite && hit_ctrl) begin
        ctrl_reg <= pwdata[1:0];
      end
      // Latest CPU access only
      if (locked && cpu_req.valid) begin
        ext_seen_reg <= ext_live;
        io_seen_reg <= io_any;
      end
    end
  end

endmodule
`default_nettype wire

// >>> shared/lcam_pkg.sv
// Constants and carriers for the legacy compatibility address map.
// Assumes an 8-bit core with a 16-bit data address and an APB register port.
`default_nettype none
package lcam_pkg;
  localparam logic [15:0] REGFILE_END = 16'h001f;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IO_END = 16'h005f;
  localparam logic [15:0] EXT_BASE = 16'h0060;
  localparam logic [15:0] EXT_END = 16'h00ff;
  localparam logic [15:0] RAM_BASE_NATIVE = 16'h0100;
  localparam logic [15:0] RAM_BASE_LEGACY = 16'h0060;
  localparam int IO_ENTRIES = 64;
  localparam logic [2:0] FUSE_SETTLE_CYCLES = 3'h4;
  // APB register offsets and fields
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam int CTRL_TIMER2_BIT = 0;
  localparam int CTRL_PCINT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_LEGACY_BIT = 0;
  localparam int STAT_LOCKED_BIT = 1;
  localparam int STAT_EXTHIT_BIT = 2;
  localparam int STAT_IOHIT_BIT = 3;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic we;
    logic [15:0] addr;
  } lcam_cpu_req_s;

  typedef struct packed {
    logic regfile_hit;
    logic io_hit;
    logic ext_hit;
    logic ram_hit;
    logic baud_high_ch0;
    logic baud_high_ch1;
    logic we;
    logic [5:0] io_index;
    logic [7:0] ext_index;
    logic [15:0] ram_offset;
  } lcam_map_sel_s;

  typedef struct packed {
    logic ext_vectors_en;
    logic wdt_timed_seq_en;
    logic rx_double_buf_en;
    logic pcint_en;
    logic second_wide_timer_en;
  } lcam_feat_s;

  typedef enum logic [2:0] {
    LCAM_SETTLE = 3'b001,
    LCAM_CAPTURE = 3'b010,
    LCAM_LOCKED = 3'b100
  } lcam_mode_e;
endpackage
`default_nettype wire

// >>> verif/lcam_cpu_model.sv
// CPU core model: one data-space or short I/O access at a time.
// Assumes procedural calls of issue on pclk.
`default_nettype none
module lcam_cpu_model
  import lcam_pkg::*;
(
  input wire logic pclk,
  output lcam_cpu_req_s cpu_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cpu_req = '0;
  task automatic issue(input logic io, input logic [15:0] a);
    // Direction follows address bit 0 so both values are seen
    @(posedge pclk) cpu_req <= '{1'b1, io, a[0], a};
    // Idle bus shows inverted address
    @(posedge pclk) cpu_req <= '{1'b0, 1'b0, 1'b0, ~a};
  endtask
endmodule
`default_nettype wire

// >>> verif/lcam_properties.sv
// Checker on the address map top-level ports.
// Assumes binding to lcam_top; one clock, async low reset.
`default_nettype none
module lcam_chk
  import lcam_pkg::*;
#(
  parameter logic [5:0] B0 = 6'h20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic mode_ready,
  input wire logic map_valid,
  input wire logic legacy_compat_fuse,
  input wire lcam_cpu_req_s cpu_req,
  input wire lcam_map_sel_s map_sel,
  input wire lcam_feat_s feat
);
  timeunit 1ns;
  timeprecision 1ps;
  lcam_cpu_req_s q;
  logic rq;
  logic lmode;
  wire logic on = rq && mode_ready;
  wire logic ext = !q.is_io && q.addr[15:8] == 8'h00 && q.addr[7:0] >= 8'h60;
  wire logic high_ram = !q.is_io && q.addr >= RAM_BASE_NATIVE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {q, rq} <= '0;
    else {q, rq} <= {cpu_req, mode_ready};
  end
  // Own copy of the mode: pin level frozen once mode_ready is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lmode <= 1'b0;
    else if (!mode_ready) lmode <= legacy_compat_fuse;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_WAIT: assert property (psel && $rose(penable) |=> pready ##1 !pready)
    else $error("ready timing");
  AST_VALID: assert property (on |-> map_valid == q.valid && map_sel.we == q.we)
    else $error("map_valid");
  AST_EXT: assert property (on && !lmode && q.valid && ext |->
    map_sel.ext_hit && map_sel.ext_index == q.addr[7:0] - 8'h60) else $error("ext decode");
  AST_IO_NO_EXT: assert property (on && q.is_io |-> !map_sel.ext_hit) else $error("io ext");
  AST_IO: assert property (on && q.valid && q.is_io && q.addr < 16'h0040 |->
    map_sel.io_hit && map_sel.io_index == q.addr[5:0]) else $error("io decode");
  AST_LEGACY: assert property (on && lmode && q.valid && ext |->
    map_sel.ram_hit && !map_sel.ext_hit && map_sel.ram_offset == q.addr - RAM_BASE_LEGACY)
    else $error("legacy ram");
  AST_RAM: assert property (on && q.valid && high_ram |-> map_sel.ram_hit &&
    map_sel.ram_offset == q.addr - (lmode ? RAM_BASE_LEGACY : RAM_BASE_NATIVE))
    else $error("ram offset");
  AST_TRIM: assert property (on && lmode |-> feat == '0)
    else $error("feature trim");
  AST_NATIVE: assert property (on && !lmode |-> feat.ext_vectors_en &&
    feat.wdt_timed_seq_en && feat.rx_double_buf_en) else $error("native features");
  AST_BAUD: assert property (on && q.valid && q.is_io && q.addr == {10'h0, B0} |->
    map_sel.baud_high_ch0 && !map_sel.baud_high_ch1) else $error("baud decode");
  AST_HOLD: assert property (on |=> mode_ready && $stable(feat.ext_vectors_en))
    else $error("mode changed");
endmodule
bind lcam_top lcam_chk #(.B0(BAUD_HIGH_CH0_IO)) u_chk(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .mode_ready(mode_ready),
  .map_valid(map_valid),
  .legacy_compat_fuse(legacy_compat_fuse),
  .cpu_req(cpu_req),
  .map_sel(map_sel),
  .feat(feat)
);
`default_nettype wire

// >>> verif/test_legacy_compat_address_map.sv
// Testbench for the legacy compatibility address map, both fuse modes.
// Assumes lcam_top, its checker and the CPU model.
`default_nettype none
module test_legacy_compat_address_map;
  import lcam_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic legacy_compat_fuse = 0, er, pready, pslverr, mode_ready, map_valid;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  lcam_cpu_req_s cpu_req;
  lcam_map_sel_s map_sel;
  lcam_feat_s feat;
  int fail_count = 0, checks = 0, cyc = 0;
  typedef struct packed {logic io; logic [15:0] a; logic [5:0] n, l;} lcam_row_s;
  // Hits: regfile, io, ext, ram, baud0, baud1; native then legacy
  lcam_row_s rows [9] = '{'{1'b0, 16'h0010, 6'h20, 6'h20}, '{1'b1, 16'h0005, 6'h10, 6'h10},
    '{1'b0, 16'h0025, 6'h10, 6'h10}, '{1'b1, 16'h0020, 6'h12, 6'h12},
    '{1'b0, 16'h005c, 6'h11, 6'h11}, '{1'b0, 16'h0060, 6'h08, 6'h04},
    '{1'b0, 16'h00ff, 6'h08, 6'h04}, '{1'b0, 16'h0100, 6'h04, 6'h04},
    '{1'b1, 16'h0060, 6'h00, 6'h00}};
  always #2.5 pclk = ~pclk;
  lcam_top dut(
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .legacy_compat_fuse(legacy_compat_fuse),
    .cpu_req(cpu_req),
    .map_sel(map_sel),
    .map_valid(map_valid),
    .mode_ready(mode_ready),
    .feat(feat)
  );
  lcam_cpu_model cpu(.pclk(pclk), .cpu_req(cpu_req));
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    for (int m = 0; m < 2; m++) begin
      legacy_compat_fuse <= m[0];
      presetn <= 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      wait (mode_ready === 1'b1);
      #1 chk(feat, m ? 5'h00 : 5'h1f);
      foreach (rows[i]) begin
        cpu.issue(rows[i].io, rows[i].a);
        #1 chk({map_valid, map_sel.regfile_hit, map_sel.io_hit, map_sel.ext_hit, map_sel.ram_hit,
          map_sel.baud_high_ch0, map_sel.baud_high_ch1},
          {1'b1, m ? rows[i].l : rows[i].n});
      end
      cpu.issue(1'b0, 16'h0080);
      apb(0, OFS_STATUS, 0);
      chk({er, rd}, {1'b0, 28'h0, 1'b0, ~m[0], 1'b1, m[0]});
      cpu.issue(1'b1, 16'h0005);
      apb(0, OFS_STATUS, 0);
      chk({er, rd}, {1'b0, 28'h0, 1'b1, 1'b0, 1'b1, m[0]});
      apb(1, OFS_STATUS, 0);
      chk(er, 1);
      apb(0, 12'h008, 0);
      chk({er, rd}, {1'b1, 32'h0});
      apb(1, OFS_CTRL, 0);
      apb(0, OFS_CTRL, 0);
      chk({er, rd}, {1'b0, 32'h0});
      legacy_compat_fuse <= ~m[0];
      repeat (8) @(posedge pclk);
      #1 chk(feat, m ? 5'h00 : 5'h1c);
    end
    results();
  end
endmodule
`default_nettype wire
